// *** logic/baud_rate_gen.sv ***
// Serial port rate generator with APB register access and bit-rate tick outputs.
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/100ps
// What this block does
// [R1] A dedicated timer, 8-bit or 16-bit, serves both asynchronous and synchronous serial operation.
// [R2] Counting starts in 8-bit mode after reset and goes 16-bit only when software sets the wide select bit.
// [R3] The divisor high and low byte pair sets the period of the free-running timer.
// [R4] In asynchronous mode the high-rate and wide selects together choose the period multiplier.
// [R5] In synchronous mode the high-rate select has no effect on the bit period.
// [R6] Writing either divisor byte clears the timer at once so the new rate starts immediately.
// [R7] Asynchronous 8-bit standard rate gives oscillator over 64 times divisor plus one.
// [R8] Software checks the receive idle flag before changing the system clock.
// [R9] Software may use high rate or the wide counter to reduce rate error and reach slow rates.
// [R10] The multiplier is 16 with exactly one select set, 4 with both, and 4 in synchronous mode.
// [R11] Each time the counter reaches the divisor it reloads to zero and emits a one-cycle tick.
module baud_rate_gen #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Serial shift logic
   input wire logic receive_idle_flag_in,
   output logic rate_tick_out,
   output logic bit_tick_out,
   output logic [6:0] multiplier_out
);
   logic [7:0] div_low_q;
   logic [7:0] div_high_q;
   baud_pkg::rate_cfg_t cfg_q;
   logic idle_meta_q;
   logic idle_sync_q;
   logic [6:0] pre_q;
   logic [6:0] pre_d;
   logic counter_tick;
   baud_pkg::apb_phase_t phase;

   wire access = psel_in && penable_in;
   wire wr_en = access && pwrite_in && pstrb_in[0];
   wire sel_low = (paddr_in == baud_pkg::ADDR_DIV_LOW);
   wire sel_high = (paddr_in == baud_pkg::ADDR_DIV_HIGH);
   wire sel_ctrl = (paddr_in == baud_pkg::ADDR_BAUD_CTRL);
   wire sel_xmit = (paddr_in == baud_pkg::ADDR_XMIT_CTRL);
   wire sel_stat = (paddr_in == baud_pkg::ADDR_STATUS);
   wire mapped = sel_low | sel_high | sel_ctrl | sel_xmit | sel_stat;
   wire div_write = wr_en && (sel_low || sel_high); // see [R6]
   wire [WIDTH-1:0] divisor = WIDTH'({div_high_q, div_low_q}); // see [R3]

   // Mode multiplier that the shift logic and the prescaler apply to each timer tick.
   wire [6:0] mult_async = (cfg_q.high_rate_select && cfg_q.wide_counter_select) ? baud_pkg::MULT_FAST :
      (cfg_q.high_rate_select || cfg_q.wide_counter_select) ? baud_pkg::MULT_MEDIUM :
      baud_pkg::MULT_STANDARD; // see [R4] see [R7] see [R10]
   wire [6:0] mult_sel = cfg_q.sync_mode ? baud_pkg::MULT_FAST : mult_async; // see [R5] see [R10]
   wire pre_wrap = counter_tick && (pre_q >= mult_sel - 7'h01);

   assign phase = !psel_in ? baud_pkg::PHASE_IDLE :
      (penable_in ? baud_pkg::PHASE_ACCESS : baud_pkg::PHASE_SETUP);

   // Read fields; unmapped addresses read zero and flag an error.
   wire [31:0] rd_low = {24'h000000, div_low_q};
   wire [31:0] rd_high = {24'h000000, div_high_q};
   wire [31:0] rd_ctrl = 32'(cfg_q.wide_counter_select) << baud_pkg::BIT_WIDE_SEL;
   wire [31:0] rd_rate = 32'(cfg_q.high_rate_select) << baud_pkg::BIT_HIGH_RATE;
   wire [31:0] rd_sync = 32'(cfg_q.sync_mode) << baud_pkg::BIT_SYNC_MODE;
   wire [31:0] rd_stat = 32'(idle_sync_q) << baud_pkg::BIT_RX_IDLE; // see [R8]
   wire [31:0] rd_mux = ({32{sel_low}} & rd_low) |
      ({32{sel_high}} & rd_high) |
      ({32{sel_ctrl}} & rd_ctrl) |
      ({32{sel_xmit}} & (rd_rate | rd_sync)) |
      ({32{sel_stat}} & rd_stat);

   // The response is launched in the setup cycle so that it stands in the first access cycle.
   wire setup_phase = (phase == baud_pkg::PHASE_SETUP);
   wire [31:0] rd_next = (setup_phase && !pwrite_in) ? rd_mux : 32'h0000_0000;
   wire err_next = setup_phase && !mapped;

   // Register write strobes.
   wire wr_low = wr_en && sel_low;
   wire wr_high = wr_en && sel_high;
   wire wr_ctrl = wr_en && sel_ctrl;
   wire wr_xmit = wr_en && sel_xmit;
   wire [7:0] wr_byte = pwdata_in[7:0];

   // Prescaler counts timer ticks up to the mode multiplier.
   wire pre_clear = div_write || pre_wrap; // see [R6]
   wire [6:0] pre_inc = pre_q + 7'h01;
   assign pre_d = pre_clear ? 7'h00 : (counter_tick ? pre_inc : pre_q);

   // A divisor write drops any tick already on its way, so the old rate leaves no late pulse.
   wire rate_next = counter_tick && !div_write; // see [R6] see [R11]
   wire bit_next = pre_wrap && !div_write; // see [R6]

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         div_low_q <= baud_pkg::DIV_RESET;
      end else if (wr_low) begin
         div_low_q <= wr_byte;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         div_high_q <= baud_pkg::DIV_RESET;
      end else if (wr_high) begin
         div_high_q <= wr_byte;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         cfg_q <= '0; // see [R2]
      end else begin
         if (wr_ctrl) begin
            cfg_q.wide_counter_select <= pwdata_in[baud_pkg::BIT_WIDE_SEL]; // see [R2]
         end
         if (wr_xmit) begin
            cfg_q.high_rate_select <= pwdata_in[baud_pkg::BIT_HIGH_RATE];
            cfg_q.sync_mode <= pwdata_in[baud_pkg::BIT_SYNC_MODE];
         end
      end
   end

   // Two-stage synchroniser for the receiver's idle level.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         idle_meta_q <= 1'b0;
      end else begin
         idle_meta_q <= receive_idle_flag_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         idle_sync_q <= 1'b0;
      end else begin
         idle_sync_q <= idle_meta_q;
      end
   end

   // Bus response registers.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         prdata_out <= 32'h0000_0000;
      end else begin
         prdata_out <= rd_next;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pready_out <= 1'b0;
      end else begin
         pready_out <= setup_phase;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pslverr_out <= 1'b0;
      end else begin
         pslverr_out <= err_next;
      end
   end

   // Prescaler and tick outputs.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pre_q <= 7'h00;
      end else begin
         pre_q <= pre_d;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         rate_tick_out <= 1'b0;
      end else begin
         rate_tick_out <= rate_next; // see [R11]
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         bit_tick_out <= 1'b0;
      end else begin
         bit_tick_out <= bit_next;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         multiplier_out <= baud_pkg::MULT_STANDARD;
      end else begin
         multiplier_out <= mult_sel; // see [R10]
      end
   end

   rate_counter #(
      .WIDTH(WIDTH)
   ) u_counter (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .clear_in(div_write),
      .wide_in(cfg_q.wide_counter_select), // see [R1] see [R2]
      .divisor_in(divisor),
      .tick_out(counter_tick)
   );
endmodule

// *** logic/baud_pkg.sv ***
// Package with register map, field positions and modes for the serial rate generator.
package baud_pkg;
   localparam logic [11:0] ADDR_DIV_LOW = 12'h000;
   localparam logic [11:0] ADDR_DIV_HIGH = 12'h004;
   localparam logic [11:0] ADDR_BAUD_CTRL = 12'h008;
   localparam logic [11:0] ADDR_XMIT_CTRL = 12'h00C;
   localparam logic [11:0] ADDR_STATUS = 12'h010;
   localparam int BIT_WIDE_SEL = 3;
   localparam int BIT_HIGH_RATE = 2;
   localparam int BIT_SYNC_MODE = 4;
   localparam int BIT_RX_IDLE = 0;
   localparam logic [7:0] DIV_RESET = 8'h00;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [6:0] MULT_STANDARD = 7'h40;
   localparam logic [6:0] MULT_MEDIUM = 7'h10;
   localparam logic [6:0] MULT_FAST = 7'h04;
   typedef struct packed {
      logic sync_mode;
      logic high_rate_select;
      logic wide_counter_select;
   } rate_cfg_t;
   typedef enum logic [1:0] {
      PHASE_IDLE = 2'b00,
      PHASE_SETUP = 2'b01,
      PHASE_ACCESS = 2'b10
   } apb_phase_t;
endpackage

// *** logic/rate_counter.sv ***
// Free-running divisor counter that emits one tick each time it reaches the divisor.
`timescale 1ns/100ps
module rate_counter #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Control
   input wire logic clear_in,
   input wire logic wide_in,
   input wire logic [WIDTH-1:0] divisor_in,
   // Tick
   output logic tick_out
);
   logic [WIDTH-1:0] count_q;
   logic [WIDTH-1:0] count_d;
   logic [WIDTH-1:0] limit;
   logic hit;

   // In 8-bit mode only the low byte of the divisor sets the period.
   assign limit = wide_in ? divisor_in : {{(WIDTH-8){1'b0}}, divisor_in[7:0]};
   assign hit = (count_q >= limit);
   assign count_d = hit ? '0 : count_q + {{(WIDTH-1){1'b0}}, 1'b1};

   always_ff @(posedge clk_in) begin
      if (sys_rst_in || clear_in) begin
         count_q <= '0; // see [R6]
         tick_out <= 1'b0;
      end else begin
         count_q <= count_d; // see [R3]
         tick_out <= hit; // see [R11]
      end
   end
endmodule

// *** verification/rate_gen_checker.sv ***
// Port checker for the serial rate generator.
`timescale 1ns/100ps
module rate_gen_checker (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [3:0] pstrb_in,
   input wire logic pready_out,
   input wire logic pslverr_out,
   input wire logic rate_tick_out,
   input wire logic bit_tick_out,
   input wire logic [6:0] multiplier_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   sequence setup_s;
      psel_in && !penable_in;
   endsequence
   sequence div_wr_s;
      psel_in && penable_in && pwrite_in && pstrb_in[0] && paddr_in[11:3] == 9'h000 && paddr_in[1:0] == 2'h0;
   endsequence
   a_ready_after_setup: assert property (setup_s |=> pready_out)
      else $error("pready late");
   a_ready_one_cycle: assert property (pready_out |=> !pready_out)
      else $error("pready held");
   a_error_with_ready: assert property (pslverr_out |-> pready_out)
      else $error("pslverr alone");
   a_unmapped_error: assert property (setup_s ##0 paddr_in > 12'h010 |=> pslverr_out)
      else $error("no pslverr");
   a_mult_after_reset: assert property ($fell(sys_rst_in) |-> multiplier_out == 7'h40)
      else $error("reset multiplier");
   a_mult_legal: assert property (multiplier_out inside {7'h40, 7'h10, 7'h04})
      else $error("bad multiplier");
   a_divisor_clear: assert property (div_wr_s |=> !rate_tick_out [*2])
      else $error("tick after clear");
   a_bit_one_cycle: assert property (bit_tick_out |=> !bit_tick_out)
      else $error("bit tick held");
endmodule
bind baud_rate_gen rate_gen_checker chk (
   .clk_in(clk_in),
   .sys_rst_in(sys_rst_in),
   .psel_in(psel_in),
   .penable_in(penable_in),
   .pwrite_in(pwrite_in),
   .paddr_in(paddr_in),
   .pstrb_in(pstrb_in),
   .pready_out(pready_out),
   .pslverr_out(pslverr_out),
   .rate_tick_out(rate_tick_out),
   .bit_tick_out(bit_tick_out),
   .multiplier_out(multiplier_out)
);

// *** verification/shift_partner.sv ***
// Model of the serial shift logic fed by the rate generator.
`timescale 1ns/100ps
module shift_partner (
   input wire logic clk_in,
   input wire logic start_in,
   input wire logic bit_tick_in,
   output logic receive_idle_flag_out
);
   logic busy_q = 1'b0;
   // A reception runs from start until the next bit tick.
   always_ff @(posedge clk_in) begin
      if (start_in) begin
         busy_q <= 1'b1;
      end else if (bit_tick_in) begin
         busy_q <= 1'b0;
      end
   end
   assign receive_idle_flag_out = !busy_q;
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the serial rate generator.
`timescale 1ns/100ps
module tb_top;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0;
   logic [3:0] pstrb_in = 4'hF;
   logic start = 1'b0;
   logic [31:0] prdata_out;
   logic pready_out, pslverr_out, rate_tick_out, bit_tick_out, receive_idle_flag_in;
   logic [6:0] multiplier_out;
   int mismatches = 0;
   int cmp_count = 0;
   int cyc = 0;
   int first, per, lim, mult;
   logic [31:0] rd;
   logic [31:0] xmit_word;
   logic err;
   baud_rate_gen dut (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .psel_in(psel_in),
      .penable_in(penable_in),
      .pwrite_in(pwrite_in),
      .paddr_in(paddr_in),
      .pwdata_in(pwdata_in),
      .pstrb_in(pstrb_in),
      .prdata_out(prdata_out),
      .pready_out(pready_out),
      .pslverr_out(pslverr_out),
      .receive_idle_flag_in(receive_idle_flag_in),
      .rate_tick_out(rate_tick_out),
      .bit_tick_out(bit_tick_out),
      .multiplier_out(multiplier_out)
   );
   shift_partner far (
      .clk_in(clk_in),
      .start_in(start),
      .bit_tick_in(bit_tick_out),
      .receive_idle_flag_out(receive_idle_flag_in)
   );
   always #25 clk_in = ~clk_in;
   task automatic stop_test;
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk_in) begin
      cyc++;
      if (cyc > 30000) begin
         mismatches++;
         stop_test();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      do begin
         @(posedge clk_in);
      end while (pready_out !== 1'b1);
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   task automatic measure(input logic sel, output int f, output int p);
      f = 0;
      p = 0;
      do begin
         @(posedge clk_in);
         #1;
         f++;
      end while ((sel ? bit_tick_out : rate_tick_out) !== 1'b1);
      do begin
         @(posedge clk_in);
         #1;
         p++;
      end while ((sel ? bit_tick_out : rate_tick_out) !== 1'b1);
   endtask
   initial begin
      repeat (8) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      check(32'(multiplier_out), 32'h40);
      apb(1'b1, baud_pkg::ADDR_DIV_HIGH, 32'h01);
      apb(1'b1, baud_pkg::ADDR_DIV_LOW, 32'hFF);
      apb(1'b0, baud_pkg::ADDR_STATUS, 32'h0);
      check(rd, 32'h1);
      start <= 1'b1;
      @(posedge clk_in);
      start <= 1'b0;
      // The idle level needs two synchroniser stages before the status read sees it.
      repeat (2) @(posedge clk_in);
      apb(1'b0, baud_pkg::ADDR_STATUS, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, baud_pkg::ADDR_DIV_HIGH, 32'h0);
      check(rd, 32'h01);
      check(32'(err), 32'h0);
      pstrb_in <= 4'h0;
      apb(1'b1, baud_pkg::ADDR_DIV_HIGH, 32'h55);
      pstrb_in <= 4'hF;
      apb(1'b0, baud_pkg::ADDR_DIV_HIGH, 32'h0);
      check(rd, 32'h01);
      apb(1'b0, 12'h020, 32'h0);
      check(32'(err), 32'h1);
      check(rd, 32'h0);
      for (int i = 0; i < 8; i++) begin
         xmit_word = 32'(i[1]) << baud_pkg::BIT_HIGH_RATE | 32'(i[2]) << baud_pkg::BIT_SYNC_MODE;
         apb(1'b1, baud_pkg::ADDR_XMIT_CTRL, xmit_word);
         apb(1'b1, baud_pkg::ADDR_BAUD_CTRL, 32'(i[0]) << baud_pkg::BIT_WIDE_SEL);
         apb(1'b0, baud_pkg::ADDR_XMIT_CTRL, 32'h0);
         check(rd, xmit_word);
         apb(1'b0, baud_pkg::ADDR_BAUD_CTRL, 32'h0);
         check(rd, 32'(i[0]) << baud_pkg::BIT_WIDE_SEL);
         apb(1'b1, baud_pkg::ADDR_DIV_LOW, 32'h03);
         lim = i[0] ? 259 : 3;
         mult = (i[2] || (i[0] && i[1])) ? 4 : (i[0] || i[1]) ? 16 : 64;
         measure(1'b0, first, per);
         check(first, lim + 2);
         check(per, lim + 1);
         check(32'(multiplier_out), mult);
         measure(1'b1, first, per);
         check(per, mult * (lim + 1));
      end
      stop_test();
   end
endmodule
